// ===== sllo_pkg.sv
package sllo_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses on the register port)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_LINK_RATE  = 8'h9C;
  localparam logic [7:0] OFS_LANE_COUNT = 8'hA0;
  localparam logic [7:0] OFS_PATTERN    = 8'hA4;
  localparam logic [7:0] OFS_LANE0      = 8'hA8;
  localparam logic [7:0] OFS_LANE1      = 8'hAC;
  localparam logic [7:0] OFS_ENABLE     = 8'hB8;

  // ----------------------------------------------------------------------
  // dpcd addresses written by the source over aux
  // ----------------------------------------------------------------------
  localparam logic [19:0] DPCD_LINK_RATE  = 20'h00100;
  localparam logic [19:0] DPCD_LANE_COUNT = 20'h00101;
  localparam logic [19:0] DPCD_PATTERN    = 20'h00102;
  localparam logic [19:0] DPCD_LANE0      = 20'h00103;
  localparam logic [19:0] DPCD_LANE1      = 20'h00104;

  // ----------------------------------------------------------------------
  // field layout and codes
  // ----------------------------------------------------------------------
  localparam logic [4:0]  RATE_1G62       = 5'h06;
  localparam logic [4:0]  RATE_2G7        = 5'h0A;
  localparam logic [4:0]  RATE_5G4        = 5'h14;
  localparam logic [4:0]  RATE_MASK_V12   = 5'h1F;
  localparam logic [4:0]  RATE_MASK_V11   = 5'h0F;
  localparam logic [7:0]  LANES_MASK_V12  = 8'hDF;
  localparam logic [7:0]  LANES_MASK_V11  = 8'h9F;
  localparam logic [15:0] PATTERN_MASK_V12 = 16'hFFF3;
  localparam logic [15:0] PATTERN_MASK_V11 = 16'hFFFF;
  localparam logic [7:0]  DRIVE_MASK      = 8'h3F;
  localparam int          ENABLE_BIT      = 0;
  localparam logic [31:0] ENABLE_VALUE    = 32'h0000_0001;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sllo_reg_req_t;

  typedef struct packed {
    logic        wr_en;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } sllo_aux_wr_t;

  typedef struct packed {
    logic [7:0] link_rate_setting;
    logic [7:0] lane_count;
    logic [7:0] training_pattern_setting;
    logic [7:0] training_poll_interval;
    logic [7:0] lane0_drive_setting;
    logic [7:0] lane1_drive_setting;
  } sllo_dpcd_t;

endpackage

// ===== sllo_field_sel.sv
`timescale 1ns/10ps
module sllo_field_sel
  import sllo_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] override_value,
  input  wire logic [WIDTH-1:0] source_value,
  output logic      [WIDTH-1:0] field
);

  typedef struct packed {
    logic [WIDTH-1:0] field;
  } sllo_sel_state_t;

  sllo_sel_state_t st;
  sllo_sel_state_t next_st;

  // override only while enabled; the stored override stays untouched otherwise
  always_comb begin
    next_st       = st;
    next_st.field = enable ? override_value : source_value;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign field = st.field;

endmodule

// ===== sllo_top.sv
`timescale 1ns/10ps
module sllo_top
  import sllo_pkg::*;
#(
  parameter bit         V12_MODE          = 1'b1,
  parameter logic [7:0] POLL_INTERVAL_DEF = 8'h00
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire sllo_reg_req_t reg_req,
  output logic      [31:0]   reg_rdata,
  output logic               reg_rvalid,
  input  wire sllo_aux_wr_t  aux_wr,
  output sllo_dpcd_t         dpcd,
  output logic               rate_code_legal
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  // asserts at once; release waits two edges so no flop leaves reset on a late edge
  logic [1:0] rst_pipe;
  logic       rst_sync_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe[1];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        enable;
    logic [4:0]  ovr_rate;
    logic [7:0]  ovr_lanes;
    logic [15:0] ovr_pattern;
    logic [7:0]  ovr_lane0;
    logic [7:0]  ovr_lane1;
    logic [7:0]  src_rate;
    logic [7:0]  src_lanes;
    logic [7:0]  src_pattern;
    logic [7:0]  src_lane0;
    logic [7:0]  src_lane1;
    logic [31:0] rdata;
    logic        rvalid;
    logic        rate_legal;
  } sllo_state_t;

  sllo_state_t st;
  sllo_state_t next_st;

  function automatic logic [4:0] rate_mask(input bit v12);
    rate_mask = v12 ? RATE_MASK_V12 : RATE_MASK_V11;
  endfunction

  function automatic logic [7:0] lanes_mask(input bit v12);
    lanes_mask = v12 ? LANES_MASK_V12 : LANES_MASK_V11;
  endfunction

  function automatic logic [15:0] pattern_mask(input bit v12);
    pattern_mask = v12 ? PATTERN_MASK_V12 : PATTERN_MASK_V11;
  endfunction

  function automatic logic is_legal_rate(input logic [7:0] code);
    is_legal_rate = (code == {3'h0, RATE_1G62}) || (code == {3'h0, RATE_2G7})
                    || (code == {3'h0, RATE_5G4});
  endfunction

  logic reg_wr_rate;
  assign reg_wr_rate = reg_req.wr_en && (reg_req.addr == OFS_LINK_RATE);

  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    // ------------------------------------------------------------------
    // host writes: contents are kept whether or not overriding is enabled
    // ------------------------------------------------------------------
    // the enable needs exactly one; any other word clears it, so stray bits never half-enable
    if (reg_req.wr_en) begin
      unique case (reg_req.addr)
        OFS_LINK_RATE:  next_st.ovr_rate    = reg_req.wdata[4:0] & rate_mask(V12_MODE);
        OFS_LANE_COUNT: next_st.ovr_lanes   = reg_req.wdata[7:0] & lanes_mask(V12_MODE);
        OFS_PATTERN:    next_st.ovr_pattern = reg_req.wdata[15:0] & pattern_mask(V12_MODE);
        OFS_LANE0:      next_st.ovr_lane0   = reg_req.wdata[7:0] & DRIVE_MASK;
        OFS_LANE1:      next_st.ovr_lane1   = reg_req.wdata[7:0] & DRIVE_MASK;
        OFS_ENABLE:     next_st.enable      = (reg_req.wdata == ENABLE_VALUE);
        default: ;
      endcase
    end
    // ------------------------------------------------------------------
    // source writes over aux always land in the shadow copy
    // ------------------------------------------------------------------
    if (aux_wr.wr_en) begin
      unique case (aux_wr.addr)
        DPCD_LINK_RATE:  next_st.src_rate    = aux_wr.wdata;
        DPCD_LANE_COUNT: next_st.src_lanes   = aux_wr.wdata;
        DPCD_PATTERN:    next_st.src_pattern = aux_wr.wdata;
        DPCD_LANE0:      next_st.src_lane0   = aux_wr.wdata;
        DPCD_LANE1:      next_st.src_lane1   = aux_wr.wdata;
        default: ;
      endcase
    end
    // ------------------------------------------------------------------
    // reads: one cycle latency, unmapped offsets read zero
    // ------------------------------------------------------------------
    if (reg_req.rd_en) begin
      next_st.rvalid = 1'b1;
      unique case (reg_req.addr)
        OFS_LINK_RATE:  next_st.rdata = {27'h0, st.ovr_rate};
        OFS_LANE_COUNT: next_st.rdata = {24'h0, st.ovr_lanes};
        OFS_PATTERN:    next_st.rdata = {16'h0, st.ovr_pattern};
        OFS_LANE0:      next_st.rdata = {24'h0, st.ovr_lane0};
        OFS_LANE1:      next_st.rdata = {24'h0, st.ovr_lane1};
        OFS_ENABLE:     next_st.rdata = {31'h0, st.enable};
        default:        next_st.rdata = 32'h0000_0000;
      endcase
    end
    // rate check covers the whole presented byte, so a bad source code shows too
    next_st.rate_legal = is_legal_rate(st.enable ? {3'h0, st.ovr_rate} : st.src_rate);
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata       = st.rdata;
  assign reg_rvalid      = st.rvalid;
  assign rate_code_legal = st.rate_legal;

  // ----------------------------------------------------------------------
  // dpcd field selection
  // ----------------------------------------------------------------------
  sllo_field_sel #(.WIDTH(48)) u_sel (
    .clk            (clk),
    .rst_n          (rst_sync_n),
    .enable         (st.enable),
    .override_value ({3'h0, st.ovr_rate, st.ovr_lanes, st.ovr_pattern[7:0], st.ovr_pattern[15:8],
                      st.ovr_lane0, st.ovr_lane1}),
    .source_value   ({st.src_rate, st.src_lanes, st.src_pattern, POLL_INTERVAL_DEF,
                      st.src_lane0, st.src_lane1}),
    .field          (dpcd)
  );

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  disabled_source_a: assert property (!st.enable |=> dpcd.link_rate_setting == $past(st.src_rate))
    else $error("source link rate not presented while disabled");
  rate_override_a: assert property (st.enable |=> dpcd.link_rate_setting == {3'h0, $past(st.ovr_rate)})
    else $error("link rate override not presented");
  rate_width_a: assert property (reg_wr_rate |=> st.ovr_rate == ($past(reg_req.wdata[4:0]) & rate_mask(V12_MODE)))
    else $error("link rate override width wrong");
  rate_legal_a: assert property (st.enable && st.ovr_rate == RATE_2G7 |=> rate_code_legal)
    else $error("legal rate code flagged illegal");
  lanes_reserved_a: assert property (dpcd.lane_count[5] == 1'b0 || !$past(st.enable))
    else $error("reserved lane count bit leaked");
  pattern_map_a: assert property (st.enable |=>
                                  dpcd.training_poll_interval == $past(st.ovr_pattern[15:8])
                                  && dpcd.training_pattern_setting == $past(st.ovr_pattern[7:0]))
    else $error("training pattern override misplaced");
  lane_drive_a: assert property (st.enable |=>
                                 dpcd.lane0_drive_setting[7:6] == 2'b00
                                 && dpcd.lane1_drive_setting == $past(st.ovr_lane1))
    else $error("lane drive override wrong");
  enable_write_a: assert property (reg_req.wr_en && reg_req.addr == OFS_ENABLE
                                   && reg_req.wdata == ENABLE_VALUE
                                   |=> st.enable ##1 dpcd.lane0_drive_setting == $past(st.ovr_lane0))
    else $error("enable write did not grant override");
  retain_a: assert property (!st.enable && !reg_wr_rate |=> $stable(st.ovr_rate))
    else $error("override contents changed while disabled");
  lanes_map_a: assert property (st.enable |=>
                                dpcd.lane_count == $past(st.ovr_lanes)
                                && dpcd.lane0_drive_setting == $past(st.ovr_lane0))
    else $error("lane count or lane 0 override not presented");
  source_stands_a: assert property (!st.enable |=>
                                    dpcd.lane_count == $past(st.src_lanes)
                                    && dpcd.training_poll_interval == POLL_INTERVAL_DEF)
    else $error("source fields not presented while disabled");
  enable_clear_a: assert property (reg_req.wr_en && reg_req.addr == OFS_ENABLE
                                   && reg_req.wdata != ENABLE_VALUE |=> !st.enable)
    else $error("enable kept after a write other than one");
  lanes_write_a: assert property (reg_req.wr_en && reg_req.addr == OFS_LANE_COUNT |=>
                                  st.ovr_lanes == ($past(reg_req.wdata[7:0]) & lanes_mask(V12_MODE)))
    else $error("lane count override bits not masked");
  pattern_write_a: assert property (reg_req.wr_en && reg_req.addr == OFS_PATTERN |=>
                                    st.ovr_pattern == ($past(reg_req.wdata[15:0]) & pattern_mask(V12_MODE)))
    else $error("pattern override bits not masked");
  drive_reserved_a: assert property (reg_req.wr_en && reg_req.addr == OFS_LANE1 |=>
                                     st.ovr_lane1[7:6] == 2'b00)
    else $error("reserved drive bits stored");
  read_answer_a: assert property (reg_req.rd_en |=> reg_rvalid)
    else $error("read not answered in one cycle");
  read_pulse_a: assert property (!reg_req.rd_en |=> !reg_rvalid)
    else $error("read valid without a read");

  // ----------------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------------
  override_on_c:  cover property (!st.enable ##1 st.enable);
  override_off_c: cover property (st.enable ##1 !st.enable);
  rate_write_c:   cover property (reg_wr_rate && reg_req.wdata[4:0] == RATE_5G4);
  aux_write_c:    cover property (aux_wr.wr_en && aux_wr.addr == DPCD_LANE0 && !st.enable);
  enable_read_c:  cover property (reg_req.rd_en && reg_req.addr == OFS_ENABLE && st.enable);

endmodule

// ===== sllo_aux_src.sv
`timescale 1ns/10ps
module sllo_aux_src
  import sllo_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [19:0] go_addr,
  input  wire logic [7:0]  go_data,
  output sllo_aux_wr_t     aux_wr
);
  // ----------------------------------------------------------------------
  // source side: one dpcd byte write per go pulse
  // ----------------------------------------------------------------------
  initial aux_wr = '0;
  // idle lines invert address and byte every cycle with write enable low, so a stale value never looks valid
  always @(posedge clk) begin
    if (go) begin
      aux_wr <= {1'b1, go_addr, go_data};
    end else begin
      aux_wr <= {1'b0, ~aux_wr.addr, ~aux_wr.wdata};
    end
  end
endmodule

// ===== sllo_top_tb.sv
`timescale 1ns/10ps
module sllo_top_tb;
  import sllo_pkg::*;
  localparam logic [7:0]  OFS [5]  = '{OFS_LINK_RATE, OFS_LANE_COUNT, OFS_PATTERN, OFS_LANE0, OFS_LANE1};
  localparam logic [19:0] ADR [5]  = '{DPCD_LINK_RATE, DPCD_LANE_COUNT, DPCD_PATTERN, DPCD_LANE0, DPCD_LANE1};
  localparam logic [31:0] MSK [5]  = '{32'h1F, 32'hDF, 32'hFFF3, 32'h3F, 32'h3F};
  localparam logic [31:0] MSK11 [5] = '{32'h0F, 32'h9F, 32'hFFFF, 32'h3F, 32'h3F};
  localparam logic [4:0]  RATE [4] = '{RATE_1G62, RATE_2G7, RATE_5G4, 5'h07};
  logic          clk;
  logic          rstn;
  logic          go;
  logic [19:0]   go_addr;
  logic [7:0]    go_data;
  sllo_reg_req_t reg_req;
  sllo_aux_wr_t  aux_wr;
  sllo_dpcd_t    dpcd;
  logic [31:0]   reg_rdata;
  logic          reg_rvalid;
  logic          rate_code_legal;
  sllo_dpcd_t    dpcd_v11;
  logic [31:0]   rdata_v11;
  logic          rvalid_v11;
  logic          legal_v11;
  logic [31:0]   ovr [5];
  logic [7:0]    src [5];
  int            mismatches;
  int            n_tests;
  int            cycles;
  integer        seed;
  bit            en;

  sllo_top u_dut (.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
                  .aux_wr(aux_wr), .dpcd(dpcd), .rate_code_legal(rate_code_legal));
  // a second copy in the v1.1a build sees the same traffic, so its narrower rate and lane count masks and full pattern mask are checked too
  sllo_top #(.V12_MODE(1'b0)) u_dut_v11 (.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(rdata_v11),
                                         .reg_rvalid(rvalid_v11), .aux_wr(aux_wr), .dpcd(dpcd_v11),
                                         .rate_code_legal(legal_v11));
  sllo_aux_src u_src (.clk(clk), .go(go), .go_addr(go_addr), .go_data(go_data), .aux_wr(aux_wr));

  // ----------------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------------
  function automatic logic legal(input logic [7:0] r);
    return (r == 8'h06) || (r == 8'h0A) || (r == 8'h14);
  endfunction

  function automatic sllo_dpcd_t want(input bit e, input bit v12);
    sllo_dpcd_t w;
    w.link_rate_setting        = e ? {3'h0, (ovr[0][4:0] & (v12 ? RATE_MASK_V12 : RATE_MASK_V11))} : src[0];
    w.lane_count               = e ? (ovr[1][7:0] & (v12 ? LANES_MASK_V12 : LANES_MASK_V11)) : src[1];
    w.training_pattern_setting = e ? (ovr[2][7:0] & (v12 ? 8'hF3 : 8'hFF)) : src[2];
    w.training_poll_interval   = e ? ovr[2][15:8] : 8'h00;
    w.lane0_drive_setting      = e ? (ovr[3][7:0] & 8'h3F) : src[3];
    w.lane1_drive_setting      = e ? (ovr[4][7:0] & 8'h3F) : src[4];
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp_v);
    n_tests++;
    if (seen !== exp_v) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp_v);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req.wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] e11);
    @(posedge clk);
    reg_req.rd_en <= 1'b1;
    reg_req.addr  <= a;
    @(posedge clk);
    reg_req.rd_en <= 1'b0;
    #1;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, e);
    chk(rvalid_v11, 1'b1);
    chk(rdata_v11, e11);
  endtask

  task automatic aux(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    go      <= 1'b1;
    go_addr <= a;
    go_data <= d;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic chk_dpcd(input bit e);
    sllo_dpcd_t w;
    sllo_dpcd_t w11;
    w   = want(e, 1'b1);
    w11 = want(e, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    chk(dpcd.link_rate_setting, w.link_rate_setting);
    chk(dpcd.lane_count, w.lane_count);
    chk(dpcd.training_pattern_setting, w.training_pattern_setting);
    chk(dpcd.training_poll_interval, w.training_poll_interval);
    chk(dpcd.lane0_drive_setting, w.lane0_drive_setting);
    chk(dpcd.lane1_drive_setting, w.lane1_drive_setting);
    chk(rate_code_legal, legal(w.link_rate_setting));
    chk(dpcd_v11, w11);
    chk(legal_v11, legal(w11.link_rate_setting));
  endtask

  task automatic close_out;
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // whole run needs about 380 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    seed = 32'h3668;
    rstn = 1'b0;
    go = 1'b0;
    go_addr = '0;
    go_data = '0;
    reg_req = '0;
    cycles = 0;
    for (int i = 0; i < 5; i++) begin
      ovr[i] = '0;
      src[i] = '0;
    end
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk_dpcd(1'b0);
    for (int i = 0; i < 5; i++) rd(OFS[i], 32'h0, 32'h0);
    rd(8'h00, 32'h0, 32'h0);
    for (int r = 0; r < 8; r++) begin
      for (int i = 0; i < 5; i++) begin
        ovr[i] = $random(seed);
        wr(OFS[i], ovr[i]);
      end
      ovr[0][4:0] = RATE[r % 4];
      ovr[1][4:0] = 5'h01 << (r % 3);
      wr(OFS[0], ovr[0]);
      wr(OFS[1], ovr[1]);
      for (int i = 0; i < 5; i++) begin
        src[i] = $random(seed);
        aux(ADR[i], src[i]);
      end
      // one round sets high bits so an out-of-range source byte must read illegal
      src[0] = {((r == 4) ? 3'h1 : 3'h0), RATE[(r + 1) % 4]};
      aux(ADR[0], src[0]);
      en = r[0];
      wr(OFS_ENABLE, en ? ENABLE_VALUE : ((r == 2) ? 32'h3 : 32'h0));
      chk_dpcd(en);
      for (int i = 0; i < 5; i++) rd(OFS[i], ovr[i] & MSK[i], ovr[i] & MSK11[i]);
      rd(OFS_ENABLE, {31'h0, en}, {31'h0, en});
    end
    close_out();
  end
endmodule
